// *** rtl/qpb_pkg.sv ***
/*
  Constants shared by both ends of the quad-pumped data phase link.
  Assumes a 100 MHz local clock at the agent that makes the bus clock.
*/
package qpb_pkg;
  localparam int DATA_W = 64;
  localparam int GROUPS = 4;
  localparam int GROUP_W = 16;
  localparam int SUBPHASES = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_PERIOD_NS = 160;
  localparam int DIV = BUS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // Position within one bus period, in local clock cycles
  localparam logic [3:0] CNT_LAST = 4'(DIV - 1);
  localparam logic [3:0] CNT_HALF = 4'(DIV / 2);
  localparam logic [3:0] CNT_TAKE = 4'h7;
  localparam logic [3:0] CNT_LOAD = 4'hF;
  // Strobe edges: a falling edge sits in the middle of each sub-phase
  localparam logic [3:0] P_FALL_A = 4'h2;
  localparam logic [3:0] P_RISE_A = 4'h6;
  localparam logic [3:0] P_FALL_B = 4'hA;
  localparam logic [3:0] P_RISE_B = 4'hE;
  localparam logic [3:0] N_FALL_A = 4'h6;
  localparam logic [3:0] N_RISE_A = 4'hA;
  localparam logic [3:0] N_FALL_B = 4'hE;
  // Inversion when half or more of a group would be driven low
  localparam logic [4:0] INV_THRESH = 5'h08;
  localparam logic [GROUP_W-1:0] GROUP_IDLE = 16'hFFFF;
endpackage : qpb_pkg

// *** rtl/qpb_if.sv ***
/*
  Wires of the quad-pumped data phase between the driving agent and the
  receiving processor agent. All link lines carry electrical levels.
*/
`timescale 1ns/100ps
`default_nettype none
interface qpb_if;
  logic bus_clk;
  logic [63:0] data;
  logic [3:0] strobe_positive;
  logic [3:0] strobe_negative;
  logic [3:0] group_inversion_flags;
  logic data_valid_flag;

  modport host (
    output bus_clk,
    output data,
    output strobe_positive,
    output strobe_negative,
    output group_inversion_flags,
    output data_valid_flag
  );
  modport dev (
    input bus_clk,
    input data,
    input strobe_positive,
    input strobe_negative,
    input group_inversion_flags,
    input data_valid_flag
  );
endinterface : qpb_if
`default_nettype wire

// *** rtl/qpb_host.sv ***
/*
  Driving agent of the data phase: divides clk into the bus clock, takes one
  64-bit word per bus period and sends it as four encoded sub-phases.
  Assumes the receiver captures on strobe falling edges and samples the
  valid flag on the rising bus clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module qpb_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic tx_valid,
  input wire logic [63:0] tx_data,
  output logic tx_ready,
  qpb_if.host bus
);
  logic [3:0] cnt_q, cnt_d;
  logic bus_clk_q, bus_clk_d;
  logic tx_ready_q, tx_ready_d;
  logic [63:0] hold_q, hold_d;
  logic hold_v_q, hold_v_d;
  logic [63:0] frame_q, frame_d;
  logic frame_v_q, frame_v_d;
  logic valid_n_q, valid_n_d;
  logic [63:0] data_q, data_d;
  logic [3:0] flag_q, flag_d;
  logic [3:0] sp_q, sp_d;
  logic [3:0] sn_q, sn_d;
  logic take;
  logic p_low, n_low;

  function automatic logic [4:0] ones(input logic [15:0] w);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < qpb_pkg::GROUP_W; i++) begin
      n = n + {4'h0, w[i]};
    end
    return n;
  endfunction : ones

  // Logical 0 drives low; inverting keeps the low count at half or less
  function automatic logic [16:0] encode(input logic [15:0] w);
    if (ones(w) > qpb_pkg::INV_THRESH) begin
      return {1'b0, w};
    end else begin
      return {1'b1, ~w};
    end
  endfunction : encode

  assign take = tx_valid && tx_ready_q;

  always_comb begin
    cnt_d = (cnt_q == qpb_pkg::CNT_LAST) ? 4'h0 : cnt_q + 4'h1;
    bus_clk_d = (cnt_d < qpb_pkg::CNT_HALF);
    tx_ready_d = (cnt_d == qpb_pkg::CNT_TAKE);
    hold_d = hold_q;
    hold_v_d = hold_v_q;
    frame_d = frame_q;
    frame_v_d = frame_v_q;
    valid_n_d = valid_n_q;
    if (take) begin
      hold_d = tx_data;
    end
    if (cnt_q == qpb_pkg::CNT_TAKE) begin
      hold_v_d = take;
      valid_n_d = !take;
    end
    if (cnt_q == qpb_pkg::CNT_LOAD) begin
      frame_d = hold_q;
      frame_v_d = hold_v_q;
      hold_v_d = 1'b0;
    end
  end

  // Sub-phase shown in a cycle is cnt[3:2] of that cycle
  always_comb begin
    p_low = frame_v_d && ((cnt_d >= qpb_pkg::P_FALL_A && cnt_d < qpb_pkg::P_RISE_A) ||
                          (cnt_d >= qpb_pkg::P_FALL_B && cnt_d < qpb_pkg::P_RISE_B));
    n_low = frame_v_d && ((cnt_d >= qpb_pkg::N_FALL_A && cnt_d < qpb_pkg::N_RISE_A) ||
                          (cnt_d >= qpb_pkg::N_FALL_B));
  end

  for (genvar g = 0; g < qpb_pkg::GROUPS; g++) begin : g_grp
    logic [15:0] word;
    logic [16:0] enc;
    always_comb begin
      word = frame_d[cnt_d[3:2] * qpb_pkg::GROUP_W + g * qpb_pkg::DATA_W / qpb_pkg::GROUPS / qpb_pkg::SUBPHASES * 0 +: 16];
      enc = encode(word);
    end
    always_comb begin
      if (frame_v_d) begin
        data_d[g*qpb_pkg::GROUP_W +: qpb_pkg::GROUP_W] = enc[15:0];
        flag_d[g] = enc[16];
      end else begin
        data_d[g*qpb_pkg::GROUP_W +: qpb_pkg::GROUP_W] = qpb_pkg::GROUP_IDLE;
        flag_d[g] = 1'b1;
      end
      sp_d[g] = !p_low;
      sn_d[g] = !n_low;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      bus_clk_q <= 1'b0;
      tx_ready_q <= 1'b0;
      hold_q <= 64'h0;
      hold_v_q <= 1'b0;
      frame_q <= 64'h0;
      frame_v_q <= 1'b0;
      valid_n_q <= 1'b1;
      data_q <= 64'hFFFF_FFFF_FFFF_FFFF;
      flag_q <= 4'hF;
      sp_q <= 4'hF;
      sn_q <= 4'hF;
    end else begin
      cnt_q <= cnt_d;
      bus_clk_q <= bus_clk_d;
      tx_ready_q <= tx_ready_d;
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
      frame_q <= frame_d;
      frame_v_q <= frame_v_d;
      valid_n_q <= valid_n_d;
      data_q <= data_d;
      flag_q <= flag_d;
      sp_q <= sp_d;
      sn_q <= sn_d;
    end
  end

  assign tx_ready = tx_ready_q;
  assign bus.bus_clk = bus_clk_q;
  assign bus.data = data_q;
  assign bus.group_inversion_flags = flag_q;
  assign bus.strobe_positive = sp_q;
  assign bus.strobe_negative = sn_q;
  assign bus.data_valid_flag = valid_n_q;
endmodule : qpb_host
`default_nettype wire

// *** rtl/qpb_dev.sv ***
/*
  Receiving processor agent of the data phase: captures each 16-bit group
  on its own strobe pair, decodes polarity and hands one word per bus clock.
  Assumes the driver holds each frame's captures stable past the next
  rising bus clock edge, as the source-synchronous timing gives.
*/
`timescale 1ns/100ps
`default_nettype none
module qpb_dev (
  input wire logic rst,
  qpb_if.dev bus,
  output logic rx_valid,
  output logic [63:0] rx_data
);
  logic valid_q, valid_d;
  logic rx_valid_q, rx_valid_d;
  logic [63:0] rx_data_q, rx_data_d;
  logic [16:0] cap [qpb_pkg::GROUPS][qpb_pkg::SUBPHASES];

  function automatic logic [15:0] decode(input logic [16:0] e);
    return e[16] ? ~e[15:0] : e[15:0];
  endfunction : decode

  for (genvar g = 0; g < qpb_pkg::GROUPS; g++) begin : g_grp
    logic psel_q, psel_d;
    logic nsel_q, nsel_d;
    logic [16:0] s0_q, s0_d, s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
    logic [16:0] line;
    always_comb begin
      line = {bus.group_inversion_flags[g], bus.data[g*qpb_pkg::GROUP_W +: qpb_pkg::GROUP_W]};
      psel_d = !psel_q;
      nsel_d = !nsel_q;
      s0_d = psel_q ? s0_q : line;
      s2_d = psel_q ? line : s2_q;
      s1_d = nsel_q ? s1_q : line;
      s3_d = nsel_q ? line : s3_q;
    end
    // Strobe pair g clocks only group g
    always_ff @(negedge bus.strobe_positive[g] or posedge rst) begin
      if (rst) begin
        psel_q <= 1'b0;
        s0_q <= 17'h0;
        s2_q <= 17'h0;
      end else begin
        psel_q <= psel_d;
        s0_q <= s0_d;
        s2_q <= s2_d;
      end
    end
    always_ff @(negedge bus.strobe_negative[g] or posedge rst) begin
      if (rst) begin
        nsel_q <= 1'b0;
        s1_q <= 17'h0;
        s3_q <= 17'h0;
      end else begin
        nsel_q <= nsel_d;
        s1_q <= s1_d;
        s3_q <= s3_d;
      end
    end
    assign cap[g][0] = s0_q;
    assign cap[g][1] = s1_q;
    assign cap[g][2] = s2_q;
    assign cap[g][3] = s3_q;
  end

  // Word layout: sub-phase s of lane group 0 fills bits 16s+15:16s; groups 1 to 3 are not read
  always_comb begin
    valid_d = !bus.data_valid_flag;
    rx_valid_d = valid_q;
    rx_data_d = rx_data_q;
    if (valid_q) begin
      for (int s = 0; s < qpb_pkg::SUBPHASES; s++) begin
        rx_data_d[s*qpb_pkg::GROUP_W +: qpb_pkg::GROUP_W] = decode(cap[0][s]);
      end
    end
  end

  always_ff @(posedge bus.bus_clk or posedge rst) begin
    if (rst) begin
      valid_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= 64'h0;
    end else begin
      valid_q <= valid_d;
      rx_valid_q <= rx_valid_d;
      rx_data_q <= rx_data_d;
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
endmodule : qpb_dev
`default_nettype wire

// *** verif/qpb_link_asserts.sv ***
/*
  Checker for the data phase wires between the two ends.
  Instantiated by the bench beside the interface; clk and rst are the host's.
*/
`timescale 1ns/100ps
`default_nettype none
module qpb_link_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_clk,
  input wire logic [63:0] data,
  input wire logic [3:0] strobe_positive,
  input wire logic [3:0] strobe_negative,
  input wire logic [3:0] group_inversion_flags,
  input wire logic data_valid_flag
);
  logic [3:0] ph_q;
  logic [3:0] grp_ok;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Realigned at each bus clock rise, so drift after reset is harmless
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ph_q <= 4'h0;
    else if ($rose(bus_clk)) ph_q <= 4'h1;
    else ph_q <= ph_q + 4'h1;
  end
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      grp_ok[g] = ($countones(data[g*16+:16]) >= 8) &&
        (group_inversion_flags[g] || $countones(data[g*16+:16]) > 8);
    end
  end
  a_bus_clk_period: assert property ($fell(bus_clk) |-> ##8 $rose(bus_clk) ##8 $fell(bus_clk))
    else $error("bus clock period wrong");
  a_pstrobe_pulse: assert property ($fell(strobe_positive[0]) |-> ##4 $rose(strobe_positive[0]))
    else $error("positive strobe low time wrong");
  // Second low pulse of a frame is cut short by the period boundary
  a_nstrobe_pulse: assert property ($fell(strobe_negative[0]) |->
    if (ph_q[3]) ##2 ($rose(strobe_negative[0]) && $rose(bus_clk)) else ##4 $rose(strobe_negative[0]))
    else $error("negative strobe low time wrong");
  a_pair_handover: assert property ($rose(strobe_positive[0]) |-> $fell(strobe_negative[0]))
    else $error("strobe pair out of step");
  a_strobe_lockstep: assert property ((strobe_positive == 4'h0 || strobe_positive == 4'hF) &&
    (strobe_negative == 4'h0 || strobe_negative == 4'hF))
    else $error("group strobes differ");
  a_valid_at_fall: assert property ($changed(data_valid_flag) |-> $fell(bus_clk))
    else $error("valid flag moved off the bus clock");
  a_strobe_in_frame: assert property ($fell(strobe_positive[0]) |-> !$past(data_valid_flag, 8))
    else $error("strobe outside a valid frame");
  a_subphase_edges: assert property (($changed(data) || $changed(group_inversion_flags)) |-> ph_q[1:0] == 2'h0)
    else $error("data or flags moved inside a sub-phase");
  a_inv_balance: assert property (grp_ok == 4'hF)
    else $error("group inversion flag inconsistent");
endmodule : qpb_link_asserts
`default_nettype wire

// *** verif/quad_pumped_data_bus_inversion_bench.sv ***
/*
  Bench joining driving and receiving ends, with a queue model of words.
  Assumes both ends share rst and the host divides clk into the link clock.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module quad_pumped_data_bus_inversion_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tx_valid = 1'b0;
  logic [63:0] tx_data = 64'h0;
  logic tx_ready;
  logic rx_valid;
  logic [63:0] rx_data;
  logic [63:0] exp_w;
  logic [63:0] exp_q[$];
  // Sub-phase slices with 0, 1, 16, 8, 9 and 15 asserted bits
  logic [63:0] corner [5] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h00FF_01FF_FFFE_7FFF,
    64'h5555_AAAA_0001_8000, 64'h01FF_00FF_01FF_00FF};
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  qpb_if u_qpb_if();
  qpb_host u_qpb_host(.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .bus(u_qpb_if));
  qpb_dev u_qpb_dev(.rst(rst), .bus(u_qpb_if), .rx_valid(rx_valid), .rx_data(rx_data));
  qpb_link_asserts u_asserts(.clk(clk), .rst(rst), .bus_clk(u_qpb_if.bus_clk), .data(u_qpb_if.data),
    .strobe_positive(u_qpb_if.strobe_positive), .strobe_negative(u_qpb_if.strobe_negative),
    .group_inversion_flags(u_qpb_if.group_inversion_flags), .data_valid_flag(u_qpb_if.data_valid_flag));
  always #5 clk = ~clk;
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end
  // The pulse spans a whole link period, so its low half sees each word once
  always @(negedge u_qpb_if.bus_clk) begin
    if (rx_valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) begin
        exp_w = exp_q.pop_front();
        `CHK(rx_data, exp_w)
      end
    end
  end
  // Entered at a falling edge; the word is taken at the edge after tx_ready
  task send(input logic [63:0] w);
    int k;
    tx_valid = 1'b1;
    tx_data = w;
    for (k = 0; k < 40 && tx_ready !== 1'b1; k++) @(negedge clk);
    `CHK(tx_ready, 1'b1)
    exp_q.push_back(w);
    @(negedge clk);
  endtask : send
  task pause(input int n);
    tx_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : pause
  initial begin
    void'($urandom(63373));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (corner[i]) send(corner[i]);
    pause(48);
    $display("test corner_words done");
    for (int i = 0; i < 8; i++) begin
      send({$urandom, $urandom});
      if (i % 2 == 1) pause(32);
    end
    pause(48);
    $display("test random_gaps done");
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule : quad_pumped_data_bus_inversion_bench
`default_nettype wire
